// *** hw/mxb_cfg.svh ***
// Purpose: offsets, fields, reset values and response codes for the mux port
// Assumes: included by its bare name
// Notes: Functional notes below
`ifndef MXB_CFG_SVH
`define MXB_CFG_SVH
`define MXB_OFF_MUX    8'h00
`define MXB_OFF_WIDTH  8'h04
`define MXB_OFF_WAIT   8'h08
`define MXB_OFF_RDNEG  8'h0c
`define MXB_OFF_SELEXT 8'h10
`define MXB_OFF_BUS_CONTROL_ONE   8'h14
`define MXB_OFF_ADDR   8'h18
`define MXB_OFF_WDATA  8'h1c
`define MXB_OFF_CMD    8'h20
`define MXB_OFF_STAT   8'h24
`define MXB_RST_WIDTH  16'hffff
`define MXB_CMD_RD     0
`define MXB_CMD_DMA    3
`define MXB_RESP_OK    2'b00
`define MXB_RESP_ERR   2'b10
`endif

// *** hw/mxb_pkg.sv ***
// Purpose: types for the mux port
// Assumes: one-hot bus cycle states
// Notes: constants live in mxb_cfg.svh
package mxb_pkg;
	typedef enum logic [8:0] {
		S_IDLE = 9'h001, // no cycle
		S_PRE  = 9'h002, // select extension before
		S_MA1  = 9'h004, // first address cycle
		S_MAW  = 9'h008, // address stretch cycle
		S_MA2  = 9'h010, // second address cycle
		S_D1   = 9'h020, // first data cycle
		S_DW   = 9'h040, // data wait cycle
		S_D2   = 9'h080, // last data cycle
		S_POST = 9'h100  // select extension after
	} mxb_state_t;
endpackage : mxb_pkg

// *** hw/mxb_port.sv ***
// Purpose: address/data multiplexed external bus port with AXI4-Lite regs
// Assumes: single 25 MHz core_clk, async active-low reset
// Notes: all pin outputs registered; pin inputs pass two flops
//
// Our own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "mxb_cfg.svh"
module mxb_port (
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        reset_n,
	// axi4-lite slave
	input  wire logic [7:0]  s_awaddr,
	input  wire logic        s_awvalid,
	output logic             s_awready,
	input  wire logic [31:0] s_wdata,
	input  wire logic [3:0]  s_wstrb,
	input  wire logic        s_wvalid,
	output logic             s_wready,
	output logic [1:0]       s_bresp,
	output logic             s_bvalid,
	input  wire logic        s_bready,
	input  wire logic [7:0]  s_araddr,
	input  wire logic        s_arvalid,
	output logic             s_arready,
	output logic [31:0]      s_rdata,
	output logic [1:0]       s_rresp,
	output logic             s_rvalid,
	input  wire logic        s_rready,
	// external bus pins
	output logic [20:0]      addr_out,
	input  wire logic [15:0] ad_in,
	output logic [15:0]      ad_out,
	output logic [1:0]       ad_oe,
	output logic [7:0]       area_select_n,
	output logic             hold_strobe_n,
	output logic             read_strobe_n,
	output logic             upper_byte_write_strobe_n,
	output logic             lower_byte_write_strobe_n,
	output logic             cycle_begin_flag_n,
	output logic             rd_wr,
	output logic             transfer_acknowledge_n,
	input  wire logic        wait_n
);
	mxb_pkg::mxb_state_t st;      // current bus cycle state
	mxb_pkg::mxb_state_t next_st; // next bus cycle state
	// software registers
	logic [7:3]  muxed_area_enable;       // per-area mux enable
	logic        addr_phase_stretch_enable;
	logic [7:0]  width_high_select;       // per-area width high bit
	logic [7:0]  width_low_select;        // per-area width low bit
	logic [2:0]  wait_count;              // program waits
	logic        wait_pin_enable;         // honour wait_n
	logic [7:0]  read_neg;                // early read negation
	logic [7:0]  pre_ext;                 // extension before cycle
	logic [7:0]  post_ext;                // extension after cycle
	logic        ack_early_select;
	logic [20:0] cmd_addr;
	logic [15:0] cmd_wdata;
	logic        cmd_rd, cmd_dma;
	logic [1:0]  cmd_lanes;               // {upper, lower}
	logic [2:0]  cmd_area;
	logic        done;                    // sticky cycle-complete
	logic [15:0] rdata;                   // last read data
	logic [2:0]  wcnt;                    // wait counter
	// axi holding registers
	logic        aw_ok, w_ok, do_wr;
	logic [7:0]  wa;
	logic [31:0] wd, wm;
	// pin synchronisers; first stage read only by second
	logic [1:0]  wait_s;
	logic [15:0] ad_s1, ad_s2;

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			wait_s <= 2'h3;
			ad_s1  <= 16'h0000;
			ad_s2  <= 16'h0000;
		end else begin
			wait_s <= {wait_s[0], wait_n};
			ad_s1  <= ad_in;
			ad_s2  <= ad_s1;
		end
	end

	// decode of the current access
	wire cur_mux   = cmd_area >= 3'h3 && muxed_area_enable[cmd_area];
	wire cur_8     = width_high_select[cmd_area] & width_low_select[cmd_area];
	wire any_mux   = |muxed_area_enable;
	wire waiting   = wait_pin_enable && !wait_s[1];
	wire busy      = st != mxb_pkg::S_IDLE;
	wire start     = do_wr && wa == `MXB_OFF_CMD && !busy;
	wire [15:0] lane_mask = cur_8 ? 16'h00ff : 16'hffff;
	wire in_addr   = next_st == mxb_pkg::S_MA1 || next_st == mxb_pkg::S_MAW
		|| next_st == mxb_pkg::S_MA2;
	wire in_data   = next_st == mxb_pkg::S_D1 || next_st == mxb_pkg::S_DW
		|| next_st == mxb_pkg::S_D2;

	// bus cycle sequencer; waits only touch data states
	always_comb begin
		next_st = st;
		case (st)
			mxb_pkg::S_IDLE: if (start) begin
				// command fields come from the held write data, not the live bus
				if (pre_ext[wd[6:4]]) next_st = mxb_pkg::S_PRE;
				else if (wd[6:4] >= 3'h3 && muxed_area_enable[wd[6:4]])
					next_st = mxb_pkg::S_MA1;
				else next_st = mxb_pkg::S_D1;
			end else next_st = mxb_pkg::S_IDLE;
			mxb_pkg::S_PRE:  next_st = cur_mux ? mxb_pkg::S_MA1 : mxb_pkg::S_D1;
			mxb_pkg::S_MA1:  next_st = addr_phase_stretch_enable ? mxb_pkg::S_MAW
				: mxb_pkg::S_MA2;
			mxb_pkg::S_MAW:  next_st = mxb_pkg::S_MA2;
			mxb_pkg::S_MA2:  next_st = mxb_pkg::S_D1;
			mxb_pkg::S_D1:   next_st = (wait_count != 3'h0 || waiting) ? mxb_pkg::S_DW
				: mxb_pkg::S_D2;
			mxb_pkg::S_DW:   next_st = (wcnt > 3'h1 || waiting) ? mxb_pkg::S_DW
				: mxb_pkg::S_D2;
			mxb_pkg::S_D2:   next_st = post_ext[cmd_area] ? mxb_pkg::S_POST
				: mxb_pkg::S_IDLE;
			mxb_pkg::S_POST: next_st = mxb_pkg::S_IDLE;
			default:         next_st = mxb_pkg::S_IDLE;
		endcase
	end

	// pin values for the coming state, registered below
	wire        n_rd  = start ? wd[`MXB_CMD_RD] : cmd_rd;
	wire [2:0]  n_ar  = start ? wd[6:4] : cmd_area;
	// area-dependent values follow the new command already at its start edge
	wire        n_8   = width_high_select[n_ar] & width_low_select[n_ar];
	wire [15:0] n_mask = n_8 ? 16'h00ff : 16'hffff;
	wire        n_dma = start ? wd[`MXB_CMD_DMA] : cmd_dma;
	wire [1:0]  n_ln  = start ? wd[2:1] : cmd_lanes;
	wire        n_sel = next_st != mxb_pkg::S_IDLE;
	wire        n_hs  = any_mux ? (next_st == mxb_pkg::S_MA1 || next_st == mxb_pkg::S_MAW)
		: in_data;
	wire        n_rds = n_rd && in_data && !(next_st == mxb_pkg::S_D2 && read_neg[n_ar]);
	wire        n_wr  = !n_rd && in_data && next_st != mxb_pkg::S_D1;
	wire        n_up  = n_wr && !n_8 && n_ln[1];
	wire        n_lo  = n_wr && n_ln[0];
	wire        n_ack = n_dma && (in_data || (ack_early_select && next_st ==
		mxb_pkg::S_MA2));
	wire [1:0]  n_oe  = (in_addr || (in_data && !n_rd)) ? {!n_8, 1'b1} : 2'h0;
	wire [15:0] n_ad  = (in_addr ? cmd_addr[15:0] : cmd_wdata) & n_mask;

	// registered pins
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			st                        <= mxb_pkg::S_IDLE;
			area_select_n             <= 8'hff;
			hold_strobe_n             <= 1'b1;
			read_strobe_n             <= 1'b1;
			upper_byte_write_strobe_n <= 1'b1;
			lower_byte_write_strobe_n <= 1'b1;
			cycle_begin_flag_n        <= 1'b1;
			rd_wr                     <= 1'b1;
			transfer_acknowledge_n    <= 1'b1;
			ad_oe                     <= 2'h0;
			ad_out                    <= 16'h0000;
			addr_out                  <= 21'h000000;
		end else begin
			st                        <= next_st;
			area_select_n             <= ~({7'h00, n_sel} << n_ar);
			hold_strobe_n             <= !n_hs;
			read_strobe_n             <= !n_rds;
			upper_byte_write_strobe_n <= !n_up;
			lower_byte_write_strobe_n <= !n_lo;
			cycle_begin_flag_n        <= !((start && next_st != mxb_pkg::S_PRE)
				|| st == mxb_pkg::S_PRE);
			rd_wr                     <= n_rd || !n_sel;
			transfer_acknowledge_n    <= !n_ack;
			ad_oe                     <= n_oe;
			ad_out                    <= n_ad;
			addr_out                  <= start ? cmd_addr : addr_out;
		end
	end

	// wait counter and read capture
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			wcnt  <= 3'h0;
			rdata <= 16'h0000;
		end else begin
			wcnt  <= (st == mxb_pkg::S_D1) ? wait_count
				: (wcnt != 3'h0 ? wcnt - 3'h1 : 3'h0);
			if (st == mxb_pkg::S_D2 && cmd_rd) rdata <= ad_s2 & lane_mask;
		end
	end

	// axi write side: address and data taken in either order
	assign do_wr = aw_ok && w_ok && !s_bvalid;
	assign wm    = {{8{s_wstrb[3]}}, {8{s_wstrb[2]}}, {8{s_wstrb[1]}}, {8{s_wstrb[0]}}};
	wire wr_known = wa <= `MXB_OFF_STAT && wa[1:0] == 2'h0;
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			aw_ok     <= 1'b0;
			w_ok      <= 1'b0;
			wa        <= 8'h00;
			wd        <= 32'h00000000;
			s_awready <= 1'b1;
			s_wready  <= 1'b1;
			s_bvalid  <= 1'b0;
			s_bresp   <= `MXB_RESP_OK;
		end else begin
			if (s_awvalid && s_awready) begin
				aw_ok     <= 1'b1;
				wa        <= s_awaddr;
				s_awready <= 1'b0;
			end
			if (s_wvalid && s_wready) begin
				w_ok     <= 1'b1;
				wd       <= s_wdata & wm;
				s_wready <= 1'b0;
			end
			if (do_wr) begin
				s_bvalid <= 1'b1;
				s_bresp  <= wr_known ? `MXB_RESP_OK : `MXB_RESP_ERR;
			end
			if (s_bvalid && s_bready) begin
				s_bvalid  <= 1'b0;
				aw_ok     <= 1'b0;
				w_ok      <= 1'b0;
				s_awready <= 1'b1;
				s_wready  <= 1'b1;
			end
		end
	end

	// register writes; a command while busy is ignored
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			muxed_area_enable         <= 5'h00;
			addr_phase_stretch_enable <= 1'b0;
			{width_high_select, width_low_select} <= `MXB_RST_WIDTH;
			wait_count                <= 3'h0;
			wait_pin_enable           <= 1'b0;
			read_neg                  <= 8'h00;
			pre_ext                   <= 8'h00;
			post_ext                  <= 8'h00;
			ack_early_select          <= 1'b0;
			cmd_addr                  <= 21'h000000;
			cmd_wdata                 <= 16'h0000;
			cmd_rd                    <= 1'b1;
			cmd_dma                   <= 1'b0;
			cmd_lanes                 <= 2'h0;
			cmd_area                  <= 3'h0;
			done                      <= 1'b0;
		end else begin
			if (do_wr) begin
				case (wa)
					`MXB_OFF_MUX: begin
						muxed_area_enable         <= wd[7:3];
						addr_phase_stretch_enable <= wd[0];
					end
					`MXB_OFF_WIDTH: {width_high_select, width_low_select} <= wd[15:0];
					`MXB_OFF_WAIT: {wait_pin_enable, wait_count} <= wd[3:0];
					`MXB_OFF_RDNEG: read_neg <= wd[7:0];
					`MXB_OFF_SELEXT: {pre_ext, post_ext} <= wd[15:0];
					`MXB_OFF_BUS_CONTROL_ONE: ack_early_select <= wd[0];
					`MXB_OFF_ADDR: cmd_addr <= wd[20:0];
					`MXB_OFF_WDATA: cmd_wdata <= wd[15:0];
					default: ;
				endcase
			end
			if (start) begin
				cmd_rd    <= wd[`MXB_CMD_RD];
				cmd_lanes <= wd[2:1];
				cmd_dma   <= wd[`MXB_CMD_DMA];
				cmd_area  <= wd[6:4];
			end
			// completion sets over a same-cycle clear
			if (st == mxb_pkg::S_D2) done <= 1'b1;
			else if (do_wr && wa == `MXB_OFF_STAT && wd[1]) done <= 1'b0;
		end
	end

	// axi read side
	wire [31:0] rd_mux =
		s_araddr == `MXB_OFF_MUX    ? {24'h0, muxed_area_enable, 2'h0, addr_phase_stretch_enable} :
		s_araddr == `MXB_OFF_WIDTH  ? {16'h0, width_high_select, width_low_select} :
		s_araddr == `MXB_OFF_WAIT   ? {28'h0, wait_pin_enable, wait_count} :
		s_araddr == `MXB_OFF_RDNEG  ? {24'h0, read_neg} :
		s_araddr == `MXB_OFF_SELEXT ? {16'h0, pre_ext, post_ext} :
		s_araddr == `MXB_OFF_BUS_CONTROL_ONE   ? {31'h0, ack_early_select} :
		s_araddr == `MXB_OFF_ADDR   ? {11'h0, cmd_addr} :
		s_araddr == `MXB_OFF_WDATA  ? {16'h0, cmd_wdata} :
		s_araddr == `MXB_OFF_STAT   ? {rdata, 14'h0, done, busy} : 32'h0;
	wire rd_known = s_araddr <= `MXB_OFF_STAT && s_araddr[1:0] == 2'h0;
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			s_arready <= 1'b1;
			s_rvalid  <= 1'b0;
			s_rdata   <= 32'h00000000;
			s_rresp   <= `MXB_RESP_OK;
		end else if (s_arvalid && s_arready) begin
			s_arready <= 1'b0;
			s_rvalid  <= 1'b1;
			s_rdata   <= rd_mux;
			s_rresp   <= rd_known ? `MXB_RESP_OK : `MXB_RESP_ERR;
		end else if (s_rvalid && s_rready) begin
			s_rvalid  <= 1'b0;
			s_arready <= 1'b1;
		end
	end

	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	property p_sel;
		busy |-> !area_select_n[cmd_area];
	endproperty
	a_sel: assert property (p_sel) else $error("area select not active");
	property p_hold;
		(any_mux && st == mxb_pkg::S_D1) |-> hold_strobe_n;
	endproperty
	a_hold: assert property (p_hold) else $error("strobe acted as address strobe");
	property p_lane8;
		(busy && cur_8) |-> !ad_oe[1];
	endproperty
	a_lane8: assert property (p_lane8) else $error("upper lane driven in 8-bit");
	property p_upper;
		cur_8 |-> upper_byte_write_strobe_n;
	endproperty
	a_upper: assert property (p_upper) else $error("upper strobe in 8-bit");
	property p_read;
		(st == mxb_pkg::S_D1 && cmd_rd) |-> !read_strobe_n && rd_wr;
	endproperty
	a_read: assert property (p_read) else $error("read strobe missing");
	property p_begin;
		(st != mxb_pkg::S_IDLE && st != mxb_pkg::S_PRE
			&& ($past(st) == mxb_pkg::S_IDLE || $past(st) == mxb_pkg::S_PRE))
			|-> !cycle_begin_flag_n;
	endproperty
	a_begin: assert property (p_begin) else $error("no cycle begin flag");
	property p_order;
		st == mxb_pkg::S_MA2 |=> st == mxb_pkg::S_D1;
	endproperty
	a_order: assert property (p_order) else $error("data phase not after address");
	property p_stretch;
		(st == mxb_pkg::S_MA1 && addr_phase_stretch_enable)
			|=> st == mxb_pkg::S_MAW ##1 st == mxb_pkg::S_MA2;
	endproperty
	a_stretch: assert property (p_stretch) else $error("stretch missing");
	property p_nowait;
		(st == mxb_pkg::S_MA1 && !addr_phase_stretch_enable) |=> st == mxb_pkg::S_MA2;
	endproperty
	a_nowait: assert property (p_nowait) else $error("address phase lengthened");
	property p_addr;
		st == mxb_pkg::S_MA1 |-> ad_out == (cmd_addr[15:0] & lane_mask) && !hold_strobe_n;
	endproperty
	a_addr: assert property (p_addr) else $error("address not on shared pins");
	property p_ack;
		(st == mxb_pkg::S_MA2 && cmd_dma) |-> transfer_acknowledge_n == !ack_early_select;
	endproperty
	a_ack: assert property (p_ack) else $error("ack timing wrong");
	c_stretch: cover property (st == mxb_pkg::S_MAW);
	c_wait:    cover property (st == mxb_pkg::S_DW ##1 st == mxb_pkg::S_DW);
	c_post:    cover property (st == mxb_pkg::S_POST);
endmodule : mxb_port

// *** verification/mxb_periph.sv ***
// Purpose: peripheral on the far side of the muxed address/data port
// Assumes: samples its hold and write strobes on core_clk, like a synchronous part
// Notes: undriven shared pins show the inverse so stale data never matches
`timescale 1ns/1ps
module mxb_periph (
	// clock
	input  wire logic        core_clk,
	// strobes from the port
	input  wire logic        hold_strobe_n,
	input  wire logic        read_strobe_n,
	input  wire logic        upper_byte_write_strobe_n,
	input  wire logic        lower_byte_write_strobe_n,
	// shared pins
	input  wire logic [15:0] ad_out,
	output logic      [15:0] ad_in,
	// what the peripheral captured
	output logic      [15:0] lat_addr,
	output logic      [15:0] wr_data
);
	logic [15:0] rd_val; // answer built from the low address byte only
	assign rd_val = {lat_addr[7:0], ~lat_addr[7:0]};
	// address follows the pins while hold is low, kept after release
	always @(posedge core_clk) begin
		if (!hold_strobe_n)
			lat_addr <= ad_out;
		if (!upper_byte_write_strobe_n)
			wr_data[15:8] <= ad_out[15:8];
		if (!lower_byte_write_strobe_n)
			wr_data[7:0] <= ad_out[7:0];
	end
	// drive only under the read strobe
	assign ad_in = !read_strobe_n ? rd_val : ~rd_val;
endmodule : mxb_periph

// *** verification/mxb_port_bench.sv ***
// Purpose: self-checking bench for the muxed bus port
// Assumes: register map of mxb_cfg.svh, AXI4-Lite master here
// Notes: reads queue their expectation, a monitor compares them
`timescale 1ns/1ps
`include "mxb_cfg.svh"
module mxb_port_bench;
	logic        core_clk, reset_n, wait_n;
	logic [7:0]  s_awaddr, s_araddr, area_select_n, sel_seen;
	logic [31:0] s_wdata, s_rdata, rd_got, a, d, m;
	logic [3:0]  s_wstrb;
	logic        s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
	logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
	logic [1:0]  s_bresp, s_rresp, ad_oe, b_got, oe_seen;
	logic [20:0] addr_out;
	logic [15:0] ad_in, ad_out, lat_addr, wr_data;
	logic        hold_strobe_n, read_strobe_n, upper_byte_write_strobe_n, rd_wr;
	logic        lower_byte_write_strobe_n, cycle_begin_flag_n, transfer_acknowledge_n;
	logic [65:0] ex;
	logic [65:0] exp_q[$]; // response, mask, masked data per read
	int          fails, checks, seed, hl_tot, rs_tot, wr_tot, acyc, ack_at, sl_all, s0;
	int          at[2];
	mxb_port i_mxb_port (.core_clk, .reset_n, .s_awaddr, .s_awvalid, .s_awready,
		.s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready,
		.s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready,
		.addr_out, .ad_in, .ad_out, .ad_oe, .area_select_n, .hold_strobe_n,
		.read_strobe_n, .upper_byte_write_strobe_n, .lower_byte_write_strobe_n,
		.cycle_begin_flag_n, .rd_wr, .transfer_acknowledge_n, .wait_n);
	mxb_periph i_mxb_periph (.core_clk, .hold_strobe_n, .read_strobe_n,
		.upper_byte_write_strobe_n, .lower_byte_write_strobe_n, .ad_out, .ad_in,
		.lat_addr, .wr_data);
	// free-running clock, 40 ns period
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	// pin activity per bus cycle, restarted at the cycle begin flag; sl_all counts across all cycles
	always @(posedge core_clk) begin
		acyc <= cycle_begin_flag_n ? acyc + 1 : 1;
		hl_tot <= (cycle_begin_flag_n ? hl_tot : 0) + 32'(!hold_strobe_n);
		rs_tot <= (cycle_begin_flag_n ? rs_tot : 0) + 32'(!read_strobe_n);
		wr_tot <= (cycle_begin_flag_n ? wr_tot : 0) + 32'(!rd_wr);
		sel_seen <= (cycle_begin_flag_n ? sel_seen : 8'h00) | ~area_select_n;
		oe_seen <= (cycle_begin_flag_n ? oe_seen : 2'h0) | ad_oe;
		sl_all <= sl_all + 32'(area_select_n != 8'hff);
		if (!cycle_begin_flag_n)
			ack_at <= 0;
		else if (!transfer_acknowledge_n && ack_at == 0)
			ack_at <= acyc;
		wait_n <= ($random(seed) % 4) != 0;
	end
	// monitor: every read answer is checked against the oldest note
	always @(posedge core_clk) begin
		if (s_rvalid && s_rready) begin
			ex = exp_q.pop_front();
			cmp(s_rdata & ex[63:32], ex[31:0]);
			cmp(32'(s_rresp), 32'(ex[65:64]));
		end
	end
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp
	task automatic give_verdict();
		$display("TB: checks=%0d fails=%0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : give_verdict
	task automatic timeout();
		fails++;
		give_verdict();
	endtask : timeout
	// write: address and data offered together, each dropped when taken
	task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
		int n;
		n = 0;
		@(posedge core_clk);
		s_awaddr <= ad;
		s_wdata <= dt;
		s_awvalid <= 1'b1;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_awready)
				s_awvalid <= 1'b0;
			if (s_wready)
				s_wvalid <= 1'b0;
			n++;
		end while (!s_bvalid && n < 200);
		b_got = s_bresp;
		s_bready <= 1'b0;
		if (n == 200)
			timeout();
	endtask : wr
	// read: expectation queued first, answer kept in rd_got
	task automatic rd(input logic [7:0] ad, input logic [31:0] mk, ev, input logic [1:0] r);
		int n;
		n = 0;
		exp_q.push_back({r, mk, ev & mk});
		@(posedge core_clk);
		s_araddr <= ad;
		s_arvalid <= 1'b1;
		s_rready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_arready)
				s_arvalid <= 1'b0;
			n++;
		end while (!s_rvalid && n < 200);
		rd_got = s_rdata;
		s_rready <= 1'b0;
		if (n == 200)
			timeout();
	endtask : rd
	function automatic logic [31:0] cmd(input int ar, dm, ln, r);
		return 32'((ar << 4) | (dm << 3) | (ln << 1) | r);
	endfunction : cmd
	// one external bus cycle: load, start, poll until done, clear done
	task automatic cyc(input logic [31:0] ad, dt, cm);
		int n;
		n = 0;
		wr(`MXB_OFF_ADDR, ad);
		wr(`MXB_OFF_WDATA, dt);
		wr(`MXB_OFF_CMD, cm);
		do begin
			rd(`MXB_OFF_STAT, 32'h0, 32'h0, `MXB_RESP_OK);
			n++;
		end while (rd_got[1:0] !== 2'b10 && n < 100);
		if (n == 100)
			timeout();
		wr(`MXB_OFF_STAT, 32'h2);
	endtask : cyc
	initial begin
		seed = 83737;
		{s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 5'h00;
		{s_awaddr, s_araddr, s_wdata} = '0;
		{fails, checks} = '0;
		s_wstrb = 4'hf;
		reset_n = 1'b0;
		repeat (12) @(posedge core_clk);
		reset_n <= 1'b1;
		rd(`MXB_OFF_WIDTH, 32'hffff, `MXB_RST_WIDTH, `MXB_RESP_OK);
		rd(8'h40, 32'hffffffff, 32'h0, `MXB_RESP_ERR);
		wr(8'h40, 32'h0);
		cmp(32'(b_got), 32'(`MXB_RESP_ERR));
		// nothing muxed yet: the shared strobe still marks the access
		cyc(32'h123, 32'h55, cmd(3, 0, 3, 0));
		cmp(32'(hl_tot != 0), 32'h1);
		$display("TB: test reset and strobe done");
		wr(`MXB_OFF_WIDTH, 32'h0000e0ff);
		wr(`MXB_OFF_WAIT, 32'ha);
		cmp(32'(b_got), 32'(`MXB_RESP_OK));
		for (int ar = 3; ar < 8; ar++) begin
			wr(`MXB_OFF_MUX, 32'hf8 | 32'(ar & 1));
			m = ar > 4 ? 32'hff : 32'hffff;
			a = $random(seed) & 32'h1fffff;
			d = $random(seed) & 32'hffff;
			cyc(a, d, cmd(ar, 0, ar > 4 ? 1 : 3, 0));
			cmp(32'(wr_data) & m, d & m);
			cmp(32'(lat_addr) & m, a & m);
			cmp(32'(addr_out), a);
			cmp(hl_tot, 1 + (ar & 1));
			cmp(32'(sel_seen), 32'(1 << ar));
			cmp(32'(oe_seen), ar > 4 ? 32'h1 : 32'h3);
			cmp(32'({rs_tot != 0, wr_tot != 0}), 32'h1);
			cyc(a, d, cmd(ar, 0, ar > 4 ? 1 : 3, 1));
			cmp(32'({rs_tot != 0, wr_tot != 0}), 32'h2);
			rd(`MXB_OFF_STAT, m << 16, {a[7:0], ~a[7:0], 16'h0}, `MXB_RESP_OK);
		end
		$display("TB: test muxed areas done");
		cyc(a, d, cmd(1, 0, 3, 1));
		cmp(hl_tot, 0);
		for (int k = 0; k < 2; k++) begin
			wr(`MXB_OFF_BUS_CONTROL_ONE, 32'(k));
			cyc(a, d, cmd(3, 1, 3, 1));
			at[k] = ack_at;
		end
		cmp(at[0] - at[1], 1);
		$display("TB: test basic area and ack done");
		// pin waits off so the select and read strobe lengths are fixed
		wr(`MXB_OFF_WAIT, 32'h2);
		wr(`MXB_OFF_MUX, 32'hf8);
		for (int k = 0; k < 2; k++) begin
			wr(`MXB_OFF_SELEXT, k ? 32'h0808 : 32'h0);
			wr(`MXB_OFF_RDNEG, k ? 32'h08 : 32'h0);
			s0 = sl_all;
			cyc(a, d, cmd(3, 0, 3, 1));
			cmp(sl_all - s0, k ? 8 : 6);
			cmp(rs_tot, k ? 3 : 4);
		end
		$display("TB: test extension and negation done");
		give_verdict();
	end
endmodule : mxb_port_bench
